// ===== rtl/mfo_output_selector.sv
// multifunction digital output selector with AXI4-Lite registers
//
// Overview of operation
// - code 50 closes output while a run command waits for run delay time
// - codes 51 to 54 close output while sequence timer 1 to 4 active
// - code 58 closes output while underload flag is set
// - code 60 closes output while cooling fan alarm present
// - code 71 closes output while secondary loop feedback low
// - code 72 closes output while secondary loop feedback high
// - code A4 closes output while drive powered and running the motor
// - code A5 closes output while line feeds motor directly in bypass
// - code A6 closes output as bypass option damper actuation
// - code A9 toggles output at each press of the assigned key
// - code B2 closes while running; preheat only with run command
// - codes 100 to 1B2 select the same condition, inverted
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module mfo_output_selector (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status flags from the drive
    input wire logic runWaitDelay,
    input wire logic [3:0] seqTimerActive,
    input wire logic underloadFlag,
    input wire logic fanAlarm,
    input wire logic secondaryLoopLow,
    input wire logic secondaryLoopHigh,
    input wire logic bypassOptionDriveRelay,
    input wire logic bypassOptionLineRelay,
    input wire logic buildingAutomationInterlock,
    input wire logic driveRunning,
    input wire logic motorPreheat,
    input wire logic runCommand,
    // operator keys, one-cycle press pulses
    input wire logic operatorFunctionKeyOne,
    input wire logic operatorFunctionKeyTwo,
    // relay outputs and interrupt
    output logic [2:0] relayOut,
    output logic irq
);

    localparam int N = mfo_pkg::NUM_OUT;

    logic [mfo_pkg::CODE_W-1:0] fsel_ff [N];
    logic [N-1:0] keySel_ff;
    logic [N-1:0] toggle_ff;
    logic [N-1:0] relay_ff;
    logic [N-1:0] nxt_relay;
    logic [N-1:0] status_ff;
    logic [N-1:0] mask_ff;

    // selects the status condition for one function code
    function automatic logic pick(input logic [7:0] code, input logic tog);
        logic v;
        v = 1'b0;
        case (code)
            mfo_pkg::FN_WAIT_RUN: v = runWaitDelay;
            mfo_pkg::FN_SEQ1: v = seqTimerActive[0];
            mfo_pkg::FN_SEQ2: v = seqTimerActive[1];
            mfo_pkg::FN_SEQ3: v = seqTimerActive[2];
            mfo_pkg::FN_SEQ4: v = seqTimerActive[3];
            mfo_pkg::FN_UNDERLOAD: v = underloadFlag;
            mfo_pkg::FN_FAN_ALARM: v = fanAlarm;
            mfo_pkg::FN_LOOP2_LOW: v = secondaryLoopLow;
            mfo_pkg::FN_LOOP2_HIGH: v = secondaryLoopHigh;
            mfo_pkg::FN_BYP_DRIVE: v = bypassOptionDriveRelay;
            mfo_pkg::FN_BYP_LINE: v = bypassOptionLineRelay;
            mfo_pkg::FN_BYP_DAMPER: v = buildingAutomationInterlock;
            mfo_pkg::FN_KEY_TOGGLE: v = tog;
            mfo_pkg::FN_INTERLOCK: v = driveRunning && (!motorPreheat || runCommand);
            default: v = 1'b0;
        endcase
        return v;
    endfunction : pick

    // byte address of the register word that an address falls in
    function automatic logic [7:0] wordAddr(input logic [7:0] addr);
        return {addr[7:2], 2'h0};
    endfunction : wordAddr

    // key press seen by each output: key one when its keySel bit is 0, key two otherwise
    logic [N-1:0] keyHit;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            keyHit[i] = keySel_ff[i] ? operatorFunctionKeyTwo : operatorFunctionKeyOne;
        end
    end

    // low code and inverse bit of each output's function select
    logic [7:0] fnCode [N];
    logic [N-1:0] fnInv;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            fnCode[i] = fsel_ff[i][7:0];
            fnInv[i] = fsel_ff[i][mfo_pkg::INV_BIT];
        end
    end

    // toggles run whatever code is selected, so choosing A9 shows the current state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_ff <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (keyHit[i]) begin
                    toggle_ff[i] <= !toggle_ff[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            nxt_relay[i] = pick(fnCode[i], toggle_ff[i]) ^ fnInv[i];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_ff <= '0;
        end else begin
            relay_ff <= nxt_relay;
        end
    end

    assign relayOut = relay_ff;

    // ---- axi4-lite write path ----
    logic awHeld_ff;
    logic wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic bValid_ff;
    logic [1:0] bResp_ff;
    logic doWrite;
    logic awTake;
    logic wTake;

    assign s_axi_awready = !awHeld_ff && !bValid_ff;
    assign s_axi_wready = !wHeld_ff && !bValid_ff;
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;

    // address and data are held apart, so either may be taken first
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
        end else if (awTake) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
        end else if (wTake) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_ff <= 1'b0;
        end
    end

    logic wrAddrOk;
    always_comb begin
        unique case (wordAddr(awAddr_ff))
            mfo_pkg::ADDR_FSEL0, mfo_pkg::ADDR_FSEL1, mfo_pkg::ADDR_FSEL2,
            mfo_pkg::ADDR_STATUS, mfo_pkg::ADDR_MASK, mfo_pkg::ADDR_KEYSEL: wrAddrOk = 1'b1;
            default: wrAddrOk = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bValid_ff <= 1'b0;
        end else if (doWrite) begin
            bValid_ff <= 1'b1;
        end else if (s_axi_bready) begin
            bValid_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bResp_ff <= mfo_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bResp_ff <= wrAddrOk ? mfo_pkg::RESP_OKAY : mfo_pkg::RESP_SLVERR;
        end
    end

    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;

    // write strobes for each register except the read-only output word, high in the cycle the write lands
    logic [N-1:0] wrFsel;
    logic wrMask;
    logic wrKeySel;
    logic wrStatus;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            wrFsel[i] = doWrite && wordAddr(awAddr_ff) == 8'(i * 4);
        end
        wrMask = doWrite && wordAddr(awAddr_ff) == mfo_pkg::ADDR_MASK;
        wrKeySel = doWrite && wordAddr(awAddr_ff) == mfo_pkg::ADDR_KEYSEL;
        wrStatus = doWrite && wordAddr(awAddr_ff) == mfo_pkg::ADDR_STATUS;
    end

    // function selects; byte lane 1 carries the inverse bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                fsel_ff[i] <= mfo_pkg::FSEL_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wrFsel[i] && wStrb_ff[0]) begin
                    fsel_ff[i][7:0] <= wData_ff[7:0];
                end
                if (wrFsel[i] && wStrb_ff[1]) begin
                    fsel_ff[i][mfo_pkg::INV_BIT] <= wData_ff[8];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= mfo_pkg::MASK_RST;
        end else if (wrMask && wStrb_ff[0]) begin
            mask_ff <= wData_ff[N-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            keySel_ff <= mfo_pkg::KEYSEL_RST;
        end else if (wrKeySel && wStrb_ff[0]) begin
            keySel_ff <= wData_ff[N-1:0];
        end
    end

    // a change of an output is the event behind its sticky status bit
    logic [N-1:0] stsSet;
    assign stsSet = nxt_relay ^ relay_ff;

    // sticky change events per output; set wins over write-one-to-clear
    logic [N-1:0] stsClr;
    assign stsClr = (wrStatus && wStrb_ff[0]) ? wData_ff[N-1:0] : '0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~stsClr) | stsSet;
        end
    end

    assign irq = |(status_ff & mask_ff);

    // ---- axi4-lite read path ----
    logic rValid_ff;
    logic [31:0] rData_ff;
    logic [1:0] rResp_ff;
    logic [31:0] rdMux;
    logic rdOk;

    assign s_axi_arready = !rValid_ff;

    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        unique case (wordAddr(s_axi_araddr))
            mfo_pkg::ADDR_FSEL0: rdMux[8:0] = fsel_ff[0];
            mfo_pkg::ADDR_FSEL1: rdMux[8:0] = fsel_ff[1];
            mfo_pkg::ADDR_FSEL2: rdMux[8:0] = fsel_ff[2];
            mfo_pkg::ADDR_OUT: rdMux[N-1:0] = relay_ff;
            mfo_pkg::ADDR_STATUS: rdMux[N-1:0] = status_ff;
            mfo_pkg::ADDR_MASK: rdMux[N-1:0] = mask_ff;
            mfo_pkg::ADDR_KEYSEL: rdMux[N-1:0] = keySel_ff;
            default: rdOk = 1'b0;
        endcase
    end

    logic doRead;
    assign doRead = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rValid_ff <= 1'b0;
        end else if (doRead) begin
            rValid_ff <= 1'b1;
        end else if (s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end

    // data and response are caught with the address and stand while rvalid is high
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rData_ff <= 32'h0000_0000;
            rResp_ff <= mfo_pkg::RESP_OKAY;
        end else if (doRead) begin
            rData_ff <= rdMux;
            rResp_ff <= rdOk ? mfo_pkg::RESP_OKAY : mfo_pkg::RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;

endmodule : mfo_output_selector

// ===== rtl/mfo_pkg.sv
// package for the multifunction output selector
package mfo_pkg;
    localparam int NUM_OUT = 3;
    localparam int CODE_W = 9;
    localparam int NUM_SRC = 15;

    // function codes, low eight bits; bit 8 inverts
    localparam logic [7:0] FN_WAIT_RUN = 8'h50;
    localparam logic [7:0] FN_SEQ1 = 8'h51;
    localparam logic [7:0] FN_SEQ2 = 8'h52;
    localparam logic [7:0] FN_SEQ3 = 8'h53;
    localparam logic [7:0] FN_SEQ4 = 8'h54;
    localparam logic [7:0] FN_UNDERLOAD = 8'h58;
    localparam logic [7:0] FN_FAN_ALARM = 8'h60;
    localparam logic [7:0] FN_LOOP2_LOW = 8'h71;
    localparam logic [7:0] FN_LOOP2_HIGH = 8'h72;
    localparam logic [7:0] FN_BYP_DRIVE = 8'hA4;
    localparam logic [7:0] FN_BYP_LINE = 8'hA5;
    localparam logic [7:0] FN_BYP_DAMPER = 8'hA6;
    localparam logic [7:0] FN_KEY_TOGGLE = 8'hA9;
    localparam logic [7:0] FN_INTERLOCK = 8'hB2;
    localparam int INV_BIT = 8;

    // register byte addresses
    localparam logic [7:0] ADDR_FSEL0 = 8'h00;
    localparam logic [7:0] ADDR_FSEL1 = 8'h04;
    localparam logic [7:0] ADDR_FSEL2 = 8'h08;
    localparam logic [7:0] ADDR_OUT = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_KEYSEL = 8'h18;

    localparam logic [CODE_W-1:0] FSEL_RST = 9'h0FF;
    localparam logic [NUM_OUT-1:0] MASK_RST = 3'h0;
    localparam logic [NUM_OUT-1:0] KEYSEL_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mfo_pkg

// ===== test/mfo_relay_model.sv
// relay bank model: contacts follow the coil drive one cycle later
`timescale 1ns/1ps
module mfo_relay_model (
    // coil drive
    input wire logic sys_clk,
    input wire logic [2:0] relayOut,
    // contact state
    output logic [2:0] contactClosed
);
    always_ff @(posedge sys_clk) begin
        contactClosed <= relayOut;
    end
endmodule : mfo_relay_model

// ===== test/mfo_output_selector_checker.sv
// checker tying output 0 to the flag its function code selects, for every code but A4, A6 and A9
`timescale 1ns/1ps
module mfo_output_selector_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register writes
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic [1:0] s_axi_bresp,
    // status flags and outputs
    input wire logic runWaitDelay, underloadFlag, fanAlarm, secondaryLoopLow, secondaryLoopHigh,
    input wire logic bypassOptionLineRelay, driveRunning, motorPreheat, runCommand,
    input wire logic [3:0] seqTimerActive,
    input wire logic [2:0] relayOut
);
    logic [7:0] adrFf;
    logic [31:0] datFf;
    logic [3:0] strbFf;
    logic bvFf;
    logic [8:0] selFf;
    wire logic [7:0] code = selFf[7:0];
    wire logic inv = selFf[8];

    // shadow of the output 0 code, committed when the write response appears
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            selFf <= mfo_pkg::FSEL_RST;
            bvFf <= 1'b0;
        end else begin
            bvFf <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) adrFf <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) datFf <= s_axi_wdata;
            if (s_axi_wvalid && s_axi_wready) strbFf <= s_axi_wstrb;
            if (s_axi_bvalid && !bvFf && s_axi_bresp == 2'h0 && adrFf == 8'h00) begin
                if (strbFf[0]) selFf[7:0] <= datFf[7:0];
                if (strbFf[1]) selFf[8] <= datFf[8];
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_wait; code == 8'h50 |-> relayOut[0] == ($past(runWaitDelay) ^ inv); endproperty
    a_wait: assert property (p_wait) else $error("wait for run output wrong");
    property p_seq; code inside {[8'h51:8'h54]} |->
        (($past(seqTimerActive) >> (code[2:0] - 3'h1)) & 4'h1) == {3'h0, relayOut[0] ^ inv};
    endproperty
    a_seq: assert property (p_seq) else $error("sequence timer output wrong");
    property p_under; code == 8'h58 |-> relayOut[0] == ($past(underloadFlag) ^ inv); endproperty
    a_under: assert property (p_under) else $error("underload output wrong");
    property p_fan; code == 8'h60 |-> relayOut[0] == ($past(fanAlarm) ^ inv); endproperty
    a_fan: assert property (p_fan) else $error("fan alarm output wrong");
    property p_low; code == 8'h71 |-> relayOut[0] == ($past(secondaryLoopLow) ^ inv); endproperty
    a_low: assert property (p_low) else $error("loop low output wrong");
    property p_high; code == 8'h72 |-> relayOut[0] == ($past(secondaryLoopHigh) ^ inv);
    endproperty
    a_high: assert property (p_high) else $error("loop high output wrong");
    property p_line; code == 8'hA5 |-> relayOut[0] == ($past(bypassOptionLineRelay) ^ inv);
    endproperty
    a_line: assert property (p_line) else $error("bypass line output wrong");
    property p_run; code == 8'hB2 |-> relayOut[0] ==
        (($past(driveRunning) && (!$past(motorPreheat) || $past(runCommand))) ^ inv);
    endproperty
    a_run: assert property (p_run) else $error("interlock output wrong");
endmodule : mfo_output_selector_checker

bind mfo_output_selector mfo_output_selector_checker chk_i (.*);

// ===== test/mfo_output_selector_tb.sv
// self-checking bench for the output selector
`timescale 1ns/1ps
module mfo_output_selector_tb;
    logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] fl;
    logic [2:0] relayOut, contact;
    logic irq, k1, k2;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [7:0] codes [12] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h58, 8'h60, 8'h71, 8'h72,
        8'hA4, 8'hA5, 8'hA6};

    mfo_output_selector uut (.runWaitDelay(fl[0]), .seqTimerActive(fl[4:1]),
        .underloadFlag(fl[5]), .fanAlarm(fl[6]), .secondaryLoopLow(fl[7]),
        .secondaryLoopHigh(fl[8]), .bypassOptionDriveRelay(fl[9]), .bypassOptionLineRelay(fl[10]),
        .buildingAutomationInterlock(fl[11]), .driveRunning(fl[12]), .motorPreheat(fl[13]),
        .runCommand(fl[14]), .operatorFunctionKeyOne(k1), .operatorFunctionKeyTwo(k2), .*);
    mfo_relay_model far (.sys_clk(sys_clk), .relayOut(relayOut), .contactClosed(contact));

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one write or read; handshakes are judged on values settled before the edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tr, done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (n = 0; n < 40 && !done; n++) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            rsp = w ? s_axi_bresp : s_axi_rresp;
            rdat = s_axi_rdata;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!done) begin
            n_mismatch++;
            final_report();
        end
    endtask : bus

    task automatic look(input logic [3:0] e);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irq and relays", {28'h0, e}, {28'h0, irq, relayOut});
        chk("contacts", {29'h0, e[2:0]}, {29'h0, contact});
        @(posedge sys_clk);
    endtask : look

    task automatic press(input logic two);
        if (two) k2 <= 1'b1;
        else k1 <= 1'b1;
        @(posedge sys_clk);
        k1 <= 1'b0;
        k2 <= 1'b0;
    endtask : press

    task automatic t_regs();
        bus(1'b0, mfo_pkg::ADDR_FSEL0, 32'h0);
        chk("fsel0", {23'h0, mfo_pkg::FSEL_RST}, rdat);
        bus(1'b1, mfo_pkg::ADDR_OUT, 32'h7);
        bus(1'b0, mfo_pkg::ADDR_OUT, 32'h0);
        chk("out", 32'h0, rdat);
        bus(1'b1, 8'h1C, 32'h1);
        chk("bresp", {30'h0, mfo_pkg::RESP_SLVERR}, {30'h0, rsp});
        bus(1'b0, 8'h1C, 32'h0);
        chk("rresp", {30'h0, mfo_pkg::RESP_SLVERR}, {30'h0, rsp});
        $display("register test done");
    endtask : t_regs

    // output 0 plain, output 1 inverted, output 2 left at the unused reset code
    task automatic t_codes();
        for (int i = 0; i < 12; i++) begin
            bus(1'b1, mfo_pkg::ADDR_FSEL0, {24'h0, codes[i]});
            bus(1'b1, mfo_pkg::ADDR_FSEL1, {23'h0, 1'b1, codes[i]});
            fl <= 16'h1 << i;
            look(4'h1);
            fl <= 16'h0;
            look(4'h2);
        end
        $display("code table test done");
    endtask : t_codes

    task automatic t_b2();
        bus(1'b1, mfo_pkg::ADDR_FSEL0, 32'hB2);
        bus(1'b1, mfo_pkg::ADDR_FSEL1, 32'h1B2);
        fl <= 16'h1000;
        look(4'h1);
        fl <= 16'h3000;
        look(4'h2);
        fl <= 16'h7000;
        look(4'h1);
        $display("interlock test done");
    endtask : t_b2

    task automatic t_keys();
        fl <= 16'h0;
        bus(1'b1, mfo_pkg::ADDR_FSEL2, 32'hA9);
        bus(1'b1, mfo_pkg::ADDR_MASK, 32'h4);
        bus(1'b1, mfo_pkg::ADDR_STATUS, 32'h7);
        look(4'h2);
        press(1'b0);
        look(4'hE);
        bus(1'b1, mfo_pkg::ADDR_STATUS, 32'h4);
        look(4'h6);
        press(1'b1);
        look(4'h6);
        bus(1'b1, mfo_pkg::ADDR_KEYSEL, 32'h4);
        press(1'b1);
        look(4'hA);
        bus(1'b1, mfo_pkg::ADDR_MASK, 32'h0);
        look(4'h2);
        $display("key and interrupt test done");
    endtask : t_keys

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, k1, k2} = 7'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        fl = 16'h0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_codes();
        t_b2();
        t_keys();
        final_report();
    end
endmodule : mfo_output_selector_tb
